// *** include/cpw_pkg.sv ***
/*
 * Shared constants of the complementary PWM output stage: register byte
 * offsets, field positions, reset values, modes and sampling divisors.
 * Assumes a 32-bit AHB-Lite register bus with word aligned registers.
 */
package cpw_pkg;

	// Register byte offsets.
	localparam logic [7:0] MODE_OFS     = 8'h00;
	localparam logic [7:0] START_OFS    = 8'h04;
	localparam logic [7:0] LEVEL_OFS    = 8'h08;
	localparam logic [7:0] DTDATA_OFS   = 8'h0c;
	localparam logic [7:0] DTEN_OFS     = 8'h10;
	localparam logic [7:0] CYCBUF_OFS   = 8'h14;
	localparam logic [7:0] C3BUF_OFS    = 8'h18;
	localparam logic [7:0] DUTY0_OFS    = 8'h1c;
	localparam logic [7:0] OUTEN_OFS    = 8'h28;
	localparam logic [7:0] IOCTL_OFS    = 8'h2c;
	localparam logic [7:0] PINFN_OFS    = 8'h30;
	localparam logic [7:0] SHUT_OFS     = 8'h34;
	localparam logic [7:0] COUNT_OFS    = 8'h38;

	// Mode register values.
	localparam logic [1:0] MODE_NORMAL  = 2'h0;
	localparam logic [1:0] MODE_COMPL   = 2'h1;

	// Field positions of the shutdown, I/O control and pin function registers.
	localparam int SHUT_FLAG_BIT = 12;
	localparam int SHUT_HIZ_BIT  = 9;
	localparam int SHUT_IE_BIT   = 8;
	localparam int IOCTL_MATCH   = 8;
	localparam int PINFN_DIR     = 8;
	localparam int PINFN_DATA    = 16;

	// Shutdown input conditions.
	localparam logic [1:0] SHUT_EDGE    = 2'h0;
	localparam logic [1:0] SHUT_LOW8    = 2'h1;
	localparam logic [1:0] SHUT_LOW16   = 2'h2;
	localparam logic [1:0] SHUT_LOW128  = 2'h3;
	localparam int DIV8   = 8;
	localparam int DIV16  = 16;
	localparam int DIV128 = 128;

	// Reset values.
	localparam logic       DTEN_RST     = 1'b1;
	localparam logic [5:0] LEVEL_RST    = 6'h00;

endpackage

// *** logic/cpw_phase.sv ***
/*
 * One complementary phase: compares the offset counter pair against the
 * phase duty and yields positive and negative active requests.
 * Assumes counter three leads counter four by the dead time.
 */
`timescale 1ns/1ps
module cpw_phase #(
	parameter int W = 16
) (
	// Clock and reset.
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// Counters and settings.
	input  wire logic [W-1:0] cnt_three,
	input  wire logic [W-1:0] cnt_four,
	input  wire logic [W-1:0] duty,
	input  wire logic         dt_en,
	input  wire logic         run,
	// Active requests.
	output logic              pos_act,
	output logic              neg_act
);
	wire logic pos_raw;
	wire logic neg_raw;

	// With dead time the positive edge uses the leading counter, so a
	// gap of the dead time plus one count opens between the two active windows.
	assign pos_raw = run && (dt_en ? (cnt_three < duty) : (cnt_four < duty));
	assign neg_raw = run && !pos_raw && (dt_en ? (cnt_four > duty) : 1'b1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos_act <= 1'b0;
			neg_act <= 1'b0;
		end else begin
			pos_act <= pos_raw;
			neg_act <= neg_raw;
		end
	end

	a_no_gap_off: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(run) && !$past(dt_en) |-> neg_act == !pos_act)
		else $error("phase outputs not complementary without dead time");
endmodule

// *** logic/cpw_shutdown.sv ***
/*
 * Shutdown input: synchronises the pin, detects the selected condition
 * and keeps the sticky shutdown flag.
 * Assumes the clear request already carries the read-as-one qualifier.
 */
`timescale 1ns/1ps
module cpw_shutdown (
	// Clock and reset.
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Pin and settings.
	input  wire logic       shutdown_input_pin_n,
	input  wire logic [1:0] cond_sel,
	input  wire logic       clr_req,
	// State.
	output logic            shutdown_flag,
	output logic            high_seen
);
	logic       sync1_ff;
	logic       sync2_ff;
	logic       prev_ff;
	logic [6:0] pre_ff;
	logic       flag_ff;
	logic       hi_ff;
	wire  logic tick;
	wire  logic set_ev;
	wire  logic do_clr;
	wire  logic [6:0] pre_top;

	assign pre_top = (cond_sel == cpw_pkg::SHUT_LOW8)  ? 7'(cpw_pkg::DIV8 - 1) :
	                 (cond_sel == cpw_pkg::SHUT_LOW16) ? 7'(cpw_pkg::DIV16 - 1) :
	                 7'(cpw_pkg::DIV128 - 1);
	assign tick    = (pre_ff == pre_top);
	assign set_ev  = (cond_sel == cpw_pkg::SHUT_EDGE) ? (prev_ff && !sync2_ff) :
	                 (tick && !sync2_ff);
	// A sampled high is required first, so a pin still held low cannot
	// be cleared away in sampling mode.
	assign do_clr  = clr_req && ((cond_sel == cpw_pkg::SHUT_EDGE) || hi_ff);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			prev_ff  <= 1'b1;
		end else begin
			sync1_ff <= shutdown_input_pin_n;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_ff  <= 7'h00;
			flag_ff <= 1'b0;
			hi_ff   <= 1'b0;
		end else begin
			pre_ff  <= tick ? 7'h00 : pre_ff + 7'h01;
			flag_ff <= set_ev || (flag_ff && !do_clr);
			if (!flag_ff || do_clr)
				hi_ff <= 1'b0;
			else if (tick && sync2_ff)
				hi_ff <= 1'b1;
		end
	end

	assign shutdown_flag = flag_ff;
	assign high_seen     = hi_ff;

	a_flag_set_edge: assert property (@(posedge hclk) disable iff (!hresetn)
		cond_sel == cpw_pkg::SHUT_EDGE && prev_ff && !sync2_ff |=> flag_ff)
		else $error("falling edge did not set shutdown flag");
	a_flag_clear_ok: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(flag_ff) |-> $past(clr_req) &&
		($past(cond_sel) == cpw_pkg::SHUT_EDGE || $past(hi_ff)))
		else $error("shutdown flag cleared without valid clear");
endmodule

// *** logic/cpw_top.sv ***
/*
 * Complementary three-phase PWM output stage with dead time, pin
 * function control and output shutdown, behind an AHB-Lite slave.
 * Assumes a single AHB-Lite master; pins are resolved outside.
 */
// How it works
// - Each of six outputs has its own active level select.
// - Positive and paired negative outputs are never active together.
// - Counter three starts at the dead time value, leading counter four.
// - Dead time enable zero gives complementary waves with no gap.
// - Dead time enable clears only by zero write after reading one.
// - After reset outputs are low and pins float until assigned.
// - After reset the mode register selects normal counting.
// - I/O control sets initial level at once and match level.
// - Shutdown flag sets when the pin meets the selected condition.
// - Flag clears by zero write after read one; sampling modes also need a high sampled first.
// - Flag with high-impedance enable floats all timer pins.
// - Interrupt request only when flag set and interrupt enabled.
// - Reserved bits of the shutdown register read zero.
// - Entering complementary mode loads five buffers into compares.
`timescale 1ns/1ps
module cpw_top #(
	parameter int W = 16
) (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Output pins: positive phases 0..2, negative phases 3..5.
	output logic [5:0]       pwm_out,
	output logic [5:0]       pwm_oe_n,
	// Shutdown.
	input  wire logic        shutdown_input_pin_n,
	output logic             shutdown_irq
);
	logic [7:0]   addr_ff;
	logic         wr_ff;
	logic         rd_ff;
	logic         rwait_ff;
	logic [31:0]  rdata_ff;
	logic [1:0]   mode_ff;
	logic         start_ff;
	logic [5:0]   level_ff;
	logic [W-1:0] dead_time_data_ff;
	logic         dead_time_enable_ff;
	logic         dte_read1_ff;
	logic [W-1:0] cycbuf_ff;
	logic [W-1:0] c3buf_ff;
	logic [W-1:0] dutybuf_ff [3];
	logic [W-1:0] cyccmp_ff;
	logic [W-1:0] c3cmp_ff;
	logic [W-1:0] dutycmp_ff [3];
	logic [5:0]   outen_ff;
	logic [13:0]  ioctl_ff;
	logic [5:0]   nrm_lvl_ff;
	logic [21:0]  pinfn_ff;
	logic [1:0]   cond_ff;
	logic         ie_ff;
	logic         hiz_ff;
	logic         flag_read1_ff;
	logic [W-1:0] counter_three_ff;
	logic [W-1:0] counter_four_ff;
	logic         down_ff;

	wire logic         addr_take;
	wire logic         wr_now;
	wire logic [31:0]  rd_mux;
	wire logic         compl;
	wire logic         enter_compl;
	wire logic         trough;
	wire logic         shut_flag;
	wire logic         flag_clr;
	wire logic [15:0]  shut_rd;
	wire logic [2:0]   pos_act;
	wire logic [2:0]   neg_act;
	wire logic [5:0]   act;
	wire logic [5:0]   timer_lvl;
	wire logic [5:0]   pin_lvl;
	wire logic [5:0]   drive;
	wire logic [W-1:0] nxt_counter_four;
	wire logic         nxt_down;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// Bus front end: writes finish with no wait; reads take one wait so
	// that a read right after a write sees the written value.
	assign addr_take = hsel && htrans[1] && hready;
	assign wr_now    = wr_ff;
	assign hreadyout = !rwait_ff;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_ff  <= 8'h00;
			wr_ff    <= 1'b0;
			rd_ff    <= 1'b0;
			rwait_ff <= 1'b0;
		end else begin
			if (addr_take)
				addr_ff <= {haddr[7:2], 2'b00};
			wr_ff    <= addr_take && hwrite;
			rd_ff    <= addr_take && !hwrite;
			rwait_ff <= addr_take && !hwrite;
		end
	end

	assign shut_rd = {3'h0, shut_flag, 2'h0, hiz_ff, ie_ff, 6'h00, cond_ff};

	assign rd_mux =
		hit(addr_ff, cpw_pkg::MODE_OFS)   ? {30'h0, mode_ff} :
		hit(addr_ff, cpw_pkg::START_OFS)  ? {31'h0, start_ff} :
		hit(addr_ff, cpw_pkg::LEVEL_OFS)  ? {26'h0, level_ff} :
		hit(addr_ff, cpw_pkg::DTDATA_OFS) ? 32'(dead_time_data_ff) :
		hit(addr_ff, cpw_pkg::DTEN_OFS)   ? {31'h0, dead_time_enable_ff} :
		hit(addr_ff, cpw_pkg::CYCBUF_OFS) ? 32'(cycbuf_ff) :
		hit(addr_ff, cpw_pkg::C3BUF_OFS)  ? 32'(c3buf_ff) :
		hit(addr_ff, cpw_pkg::DUTY0_OFS)  ? 32'(dutybuf_ff[0]) :
		hit(addr_ff, cpw_pkg::DUTY0_OFS + 8'h04) ? 32'(dutybuf_ff[1]) :
		hit(addr_ff, cpw_pkg::DUTY0_OFS + 8'h08) ? 32'(dutybuf_ff[2]) :
		hit(addr_ff, cpw_pkg::OUTEN_OFS)  ? {26'h0, outen_ff} :
		hit(addr_ff, cpw_pkg::IOCTL_OFS)  ? {18'h0, ioctl_ff} :
		hit(addr_ff, cpw_pkg::PINFN_OFS)  ? {10'h0, pinfn_ff} :
		hit(addr_ff, cpw_pkg::SHUT_OFS)   ? {16'h0, shut_rd} :
		hit(addr_ff, cpw_pkg::COUNT_OFS)  ?
			{16'(counter_three_ff), 16'(counter_four_ff)} :
		32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rdata_ff <= 32'h0000_0000;
		else if (rd_ff)
			rdata_ff <= rd_mux;
	end

	// Read-as-one memory for the two bits that clear only after a read.
	assign flag_clr = wr_now && hit(addr_ff, cpw_pkg::SHUT_OFS) &&
	                  !hwdata[cpw_pkg::SHUT_FLAG_BIT] && flag_read1_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dte_read1_ff  <= 1'b0;
			flag_read1_ff <= 1'b0;
		end else begin
			// A write to the enable register consumes the read, so only a read of one
			// since the last such write can clear the enable.
			if (rd_ff && hit(addr_ff, cpw_pkg::DTEN_OFS))
				dte_read1_ff <= dead_time_enable_ff;
			else if (wr_now && hit(addr_ff, cpw_pkg::DTEN_OFS))
				dte_read1_ff <= 1'b0;
			if (rd_ff && hit(addr_ff, cpw_pkg::SHUT_OFS))
				flag_read1_ff <= shut_flag;
			else if (flag_clr)
				flag_read1_ff <= 1'b0;
		end
	end

	assign compl       = (mode_ff == cpw_pkg::MODE_COMPL);
	assign enter_compl = wr_now && hit(addr_ff, cpw_pkg::MODE_OFS) &&
	                     (hwdata[1:0] == cpw_pkg::MODE_COMPL) && !compl;

	// Control registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_ff             <= cpw_pkg::MODE_NORMAL;
			start_ff            <= 1'b0;
			level_ff            <= cpw_pkg::LEVEL_RST;
			dead_time_data_ff   <= '0;
			dead_time_enable_ff <= cpw_pkg::DTEN_RST;
			cycbuf_ff           <= '0;
			c3buf_ff            <= '0;
			outen_ff            <= 6'h00;
			ioctl_ff            <= 14'h0000;
			pinfn_ff            <= 22'h000000;
			cond_ff             <= cpw_pkg::SHUT_EDGE;
			ie_ff               <= 1'b0;
			hiz_ff              <= 1'b0;
		end else if (wr_now) begin
			if (hit(addr_ff, cpw_pkg::MODE_OFS))
				mode_ff <= hwdata[1:0];
			if (hit(addr_ff, cpw_pkg::START_OFS))
				start_ff <= hwdata[0];
			if (hit(addr_ff, cpw_pkg::LEVEL_OFS))
				level_ff <= hwdata[5:0];
			if (hit(addr_ff, cpw_pkg::DTDATA_OFS))
				dead_time_data_ff <= hwdata[W-1:0];
			if (hit(addr_ff, cpw_pkg::DTEN_OFS) && !hwdata[0] && dte_read1_ff)
				dead_time_enable_ff <= 1'b0;
			if (hit(addr_ff, cpw_pkg::CYCBUF_OFS))
				cycbuf_ff <= hwdata[W-1:0];
			if (hit(addr_ff, cpw_pkg::C3BUF_OFS))
				c3buf_ff <= hwdata[W-1:0];
			if (hit(addr_ff, cpw_pkg::OUTEN_OFS))
				outen_ff <= hwdata[5:0];
			if (hit(addr_ff, cpw_pkg::IOCTL_OFS))
				ioctl_ff <= hwdata[13:0];
			if (hit(addr_ff, cpw_pkg::PINFN_OFS))
				pinfn_ff <= hwdata[21:0];
			if (hit(addr_ff, cpw_pkg::SHUT_OFS)) begin
				cond_ff <= hwdata[1:0];
				ie_ff   <= hwdata[cpw_pkg::SHUT_IE_BIT];
				hiz_ff  <= hwdata[cpw_pkg::SHUT_HIZ_BIT];
			end
		end
	end

	// Duty buffers and their compares; the five buffers move together.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyccmp_ff <= '0;
			c3cmp_ff  <= '0;
			for (int i = 0; i < 3; i++) begin
				dutybuf_ff[i] <= '0;
				dutycmp_ff[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 3; i++)
				if (wr_now && hit(addr_ff, cpw_pkg::DUTY0_OFS + 8'(4 * i)))
					dutybuf_ff[i] <= hwdata[W-1:0];
			if (enter_compl || (compl && trough) || !compl) begin
				cyccmp_ff <= cycbuf_ff;
				c3cmp_ff  <= c3buf_ff;
				for (int i = 0; i < 3; i++)
					dutycmp_ff[i] <= dutybuf_ff[i];
			end
		end
	end

	// Counters: normal mode counts up to the channel three compare;
	// complementary mode counts up to the cycle compare and back.
	assign trough   = down_ff && (counter_four_ff == '0);
	assign nxt_down = compl && (down_ff ? (counter_four_ff != '0) :
	                  (counter_four_ff >= cyccmp_ff));
	assign nxt_counter_four =
		!compl ? ((counter_four_ff >= c3cmp_ff) ? '0 : counter_four_ff + W'(1)) :
		(nxt_down ? counter_four_ff - W'(1) : counter_four_ff + W'(1));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter_four_ff  <= '0;
			counter_three_ff <= '0;
			down_ff          <= 1'b0;
		end else if (wr_now && hit(addr_ff, cpw_pkg::COUNT_OFS)) begin
			// Software loads both counters with the written value here; entering
			// complementary mode then restores the dead time offset of counter three.
			counter_four_ff  <= hwdata[W-1:0];
			counter_three_ff <= hwdata[W-1:0];
			down_ff          <= 1'b0;
		end else if (enter_compl) begin
			counter_three_ff <= dead_time_data_ff;
			down_ff          <= 1'b0;
		end else if (start_ff) begin
			counter_four_ff  <= nxt_counter_four;
			counter_three_ff <= nxt_counter_four + dead_time_data_ff;
			down_ff          <= !nxt_down ? 1'b0 : 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_phase
			cpw_phase #(.W(W)) u_phase (
				.hclk      (hclk),
				.hresetn   (hresetn),
				.cnt_three (counter_three_ff),
				.cnt_four  (counter_four_ff),
				.duty      (dutycmp_ff[g]),
				.dt_en     (dead_time_enable_ff),
				.run       (compl && start_ff),
				.pos_act   (pos_act[g]),
				.neg_act   (neg_act[g])
			);
		end
	endgenerate

	// Normal mode levels: an I/O control write sets the level at once,
	// a compare match then drives the programmed match level.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			nrm_lvl_ff <= 6'h00;
		else if (wr_now && hit(addr_ff, cpw_pkg::IOCTL_OFS))
			nrm_lvl_ff <= hwdata[5:0];
		else if (!compl && start_ff)
			for (int i = 0; i < 6; i++)
				if (counter_four_ff == dutycmp_ff[i % 3])
					nrm_lvl_ff[i] <= ioctl_ff[cpw_pkg::IOCTL_MATCH + i];
	end

	cpw_shutdown u_shut (
		.hclk                 (hclk),
		.hresetn              (hresetn),
		.shutdown_input_pin_n (shutdown_input_pin_n),
		.cond_sel             (cond_ff),
		.clr_req              (flag_clr),
		.shutdown_flag        (shut_flag),
		.high_seen            ()
	);

	// Pin assembly. The level select bit gives the active level; a zero
	// selects active low, so an idle complementary pin sits high.
	assign act       = {neg_act, pos_act};
	assign timer_lvl = compl ? (act ~^ level_ff) : nrm_lvl_ff;
	assign pin_lvl   = pinfn_ff[5:0] & timer_lvl |
	                   ~pinfn_ff[5:0] & pinfn_ff[cpw_pkg::PINFN_DATA +: 6];
	assign drive     = (pinfn_ff[5:0] & outen_ff) |
	                   (~pinfn_ff[5:0] & pinfn_ff[cpw_pkg::PINFN_DIR +: 6]);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwm_out  <= 6'h00;
			pwm_oe_n <= 6'h3f;
		end else begin
			pwm_out  <= pin_lvl;
			pwm_oe_n <= (shut_flag && hiz_ff) ? 6'h3f : ~drive;
		end
	end

	assign shutdown_irq = shut_flag && ie_ff;

	a_no_overlap: assert property (@(posedge hclk) disable iff (!hresetn)
		(pos_act & neg_act) == 3'h0)
		else $error("positive and negative phase active together");
	a_c3_start: assert property (@(posedge hclk) disable iff (!hresetn)
		enter_compl |=> counter_three_ff == $past(dead_time_data_ff))
		else $error("counter three not loaded with dead time");
	a_dte_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(dead_time_enable_ff) |-> $past(dte_read1_ff) && $past(wr_now))
		else $error("dead time enable cleared without read of one");
	a_hiz_force: assert property (@(posedge hclk) disable iff (!hresetn)
		shut_flag && hiz_ff |=> pwm_oe_n == 6'h3f)
		else $error("pins driven during shutdown");
	a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		shutdown_irq == (shut_flag && ie_ff))
		else $error("shutdown interrupt request wrong");
	a_resv_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_ff && hit(addr_ff, cpw_pkg::SHUT_OFS) |=>
		(hrdata[15:13] == 3'h0) && (hrdata[11:10] == 2'h0))
		else $error("reserved shutdown bits read nonzero");
	a_buf_load: assert property (@(posedge hclk) disable iff (!hresetn)
		enter_compl |=> cyccmp_ff == $past(cycbuf_ff) &&
		dutycmp_ff[0] == $past(dutybuf_ff[0]))
		else $error("buffers not transferred on entering complementary");
	a_io_init: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_now && hit(addr_ff, cpw_pkg::IOCTL_OFS) |=>
		nrm_lvl_ff == $past(hwdata[5:0]))
		else $error("initial level not applied at once");
endmodule

// *** tb/cpw_gate_model.sv ***
/*
 * Gate driver model at the six timer pins: counts cycles in which a
 * phase pair is active together or both idle, and pulls the shutdown
 * line low on request. Assumes pins are sampled on the bus clock.
 */
`timescale 1ns/1ps
module cpw_gate_model (
	// Clock and pins.
	input  wire logic       hclk,
	input  wire logic [5:0] pwm_out,
	input  wire logic [5:0] pwm_oe_n,
	input  wire logic [5:0] lvl,
	// Control and status.
	input  wire logic       fault,
	input  wire logic       watch,
	output logic            shutdown_input_pin_n,
	output int              n_overlap,
	output int              n_gap
);
	logic [5:0] act;

	// The model drives the shutdown line high whenever fault is released.
	assign shutdown_input_pin_n = fault ? 1'b0 : 1'b1;
	assign act = ~(pwm_out ^ lvl) & ~pwm_oe_n;

	always @(posedge hclk) begin
		for (int i = 0; i < 3; i++) begin
			if (watch && act[i] && act[i+3])
				n_overlap++;
			if (watch && !act[i] && !act[i+3])
				n_gap++;
		end
	end
endmodule

// *** tb/cpw_top_tb.sv ***
/*
 * Self-checking bench of the PWM output stage: AHB-Lite master tasks,
 * a register model and the gate driver model at the pins.
 * Assumes the slave answers within the bench timeout.
 */
`timescale 1ns/1ps
module cpw_top_tb;
	logic        hclk, hresetn, hsel, hwrite, fault, watch;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, g;
	logic        hreadyout, hresp, irq, pin_n;
	logic [5:0]  pwm_out, pwm_oe_n, lvl, io;
	int          num_errors, n_compared, cyc, no, ng, dt, v, gap0;
	logic [31:0] mdl [16];

	cpw_top #(.W(16)) i_cpw_top (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n),
		.shutdown_input_pin_n(pin_n), .shutdown_irq(irq));

	cpw_gate_model i_cpw_gate_model (.hclk(hclk), .pwm_out(pwm_out),
		.pwm_oe_n(pwm_oe_n), .lvl(lvl), .fault(fault), .watch(watch),
		.shutdown_input_pin_n(pin_n), .n_overlap(no), .n_gap(ng));

	function automatic logic [31:0] msk(input int i);
		case (i)
			0: msk = 32'h3;
			1: msk = 32'h1;
			2, 10: msk = 32'h3f;
			3, 5, 6, 7, 8, 9: msk = 32'hffff;
			11: msk = 32'h3f3f;
			12: msk = 32'h3f3f3f;
			13: msk = 32'h303;
			default: msk = 32'h0;
		endcase
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		g = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		if (a != cpw_pkg::DTEN_OFS)
			mdl[a[5:2]] = d & msk(int'(a[5:2]));
	endtask

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
		chk(g, mdl[a[5:2]]);
	endtask

	task automatic conclude;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	// Ceiling of roughly nine times the expected run length.
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			conclude;
		end
	end

	initial begin
		{hresetn, hsel, hwrite, fault, watch, htrans} = '0;
		{haddr, hwdata, lvl, io, num_errors, n_compared} = '0;
		hsize = 3'h2;
		foreach (mdl[i])
			mdl[i] = 32'h0;
		mdl[4] = 32'(cpw_pkg::DTEN_RST);
		v = $urandom(32'h63d4);
		repeat (4) @(posedge hclk);
		chk(32'(pwm_out), 32'h0);
		chk(32'(pwm_oe_n), 32'h3f);
		hresetn <= 1'b1;
		for (int i = 0; i < 16; i++)
			rd(8'(i * 4));
		io = 6'($urandom);
		wr(cpw_pkg::OUTEN_OFS, 32'h3f);
		wr(cpw_pkg::IOCTL_OFS, {18'h0, ~io, 2'h0, io});
		wr(cpw_pkg::PINFN_OFS, 32'h3f);
		repeat (3) @(posedge hclk);
		chk(32'(pwm_out), 32'(io));
		chk(32'(pwm_oe_n), 32'h0);
		wr(cpw_pkg::START_OFS, 32'h1);
		repeat (3) @(posedge hclk);
		chk(32'(pwm_out), {26'h0, ~io});
		wr(cpw_pkg::PINFN_OFS, {10'h0, ~io, 2'h0, 6'h3f, 8'h0});
		wr(cpw_pkg::START_OFS, 32'h0);
		wr(cpw_pkg::IOCTL_OFS, {18'h0, ~io, 2'h0, io});
		repeat (3) @(posedge hclk);
		chk(32'(pwm_out), {26'h0, ~io});
		wr(cpw_pkg::PINFN_OFS, 32'h3f);
		repeat (3) @(posedge hclk);
		chk(32'(pwm_out), 32'(io));
		for (int k = 0; k < 2; k++) begin
			if (k == 1) begin
				wr(cpw_pkg::DTEN_OFS, 32'h1);
				wr(cpw_pkg::DTEN_OFS, 32'h0);
				rd(cpw_pkg::DTEN_OFS);
				wr(cpw_pkg::DTEN_OFS, 32'h0);
				mdl[4] = 32'h0;
				rd(cpw_pkg::DTEN_OFS);
				wr(cpw_pkg::DTEN_OFS, 32'h1);
				rd(cpw_pkg::DTEN_OFS);
			end
			dt = k ? 1 : 2 + int'($urandom % 4);
			io = 6'($urandom);
			lvl <= io;
			wr(cpw_pkg::LEVEL_OFS, 32'(io));
			wr(cpw_pkg::DTDATA_OFS, 32'(dt));
			wr(cpw_pkg::CYCBUF_OFS, 32'd20);
			wr(cpw_pkg::C3BUF_OFS, 32'(20 + dt));
			for (int j = 0; j < 3; j++)
				wr(8'(28 + 4 * j), 32'(4 + $urandom % 12));
			wr(cpw_pkg::COUNT_OFS, 32'h0);
			rd(cpw_pkg::COUNT_OFS);
			wr(cpw_pkg::MODE_OFS, 32'(cpw_pkg::MODE_COMPL));
			wr(cpw_pkg::START_OFS, 32'h1);
			repeat (30) @(posedge hclk);
			watch <= 1'b1;
			repeat (300) @(posedge hclk);
			bus(1'b0, cpw_pkg::COUNT_OFS, 32'h0);
			chk(32'(16'(g[31:16] - g[15:0])), 32'(dt));
			watch <= 1'b0;
			@(posedge hclk);
			chk(32'(no), 32'h0);
			if (k == 0)
				chk(32'(ng > 0), 32'h1);
			else
				chk(32'(ng), 32'(gap0));
			gap0 = ng;
			wr(cpw_pkg::START_OFS, 32'h0);
			wr(cpw_pkg::MODE_OFS, 32'(cpw_pkg::MODE_NORMAL));
		end
		wr(cpw_pkg::SHUT_OFS, 32'hffffffff);
		rd(cpw_pkg::SHUT_OFS);
		for (int c = 0; c < 4; c++) begin
			v = c | (c % 2 ? 32'h100 : 32'h0) | (c != 2 ? 32'h200 : 32'h0);
			wr(cpw_pkg::SHUT_OFS, 32'(v));
			fault <= 1'b1;
			repeat (300) @(posedge hclk);
			chk(32'(irq), 32'(c % 2));
			chk(32'(pwm_oe_n), c != 2 ? 32'h3f : 32'h0);
			bus(1'b0, cpw_pkg::SHUT_OFS, 32'h0);
			chk(g, 32'(v) | 32'h1000);
			fault <= 1'b0;
			repeat (300) @(posedge hclk);
			wr(cpw_pkg::SHUT_OFS, 32'(v));
			rd(cpw_pkg::SHUT_OFS);
			chk(32'(irq), 32'h0);
		end
		conclude;
	end
endmodule
